// >>> design/fcp_pkg.sv
/*
 * shared constants and types for the fabric co-processor decode and response port
 * assumes both link ends and the register slave run on one clock
 */
package fcp_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int CRF_W  = 3;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // register map of the controller end
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_INSTR  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RESULT = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_ATTR   = 8'h10;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CDEC_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_RES_BIT   = 1;
    localparam int ST_ACK_BIT   = 2;
    localparam int ST_SLEEP_BIT = 3;
    localparam int ST_HOLD_BIT  = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FCP_SZ_BYTE = 2'h0,
        FCP_SZ_HALF = 2'h1,
        FCP_SZ_WORD = 2'h2
    } fcp_size_t;

    // decode answer from the user logic behind the co-processor
    typedef struct packed {
        logic             autonomous;
        logic             writeback;
        logic             op_a;
        logic             op_b;
        logic             priv;
        logic             align;
        logic             ovf;
        logic             carry;
        logic             cr_upd;
        logic [CRF_W-1:0] cr_field;
        logic             load;
        logic             store;
        logic             upd;
        fcp_size_t        size;
    } fcp_dec_t;

    // attribute flags as they travel on the link
    typedef struct packed {
        logic             writeback;
        logic             op_a;
        logic             op_b;
        logic             priv;
        logic             align;
        logic             ovf;
        logic             carry;
        logic             cr_upd;
        logic [CRF_W-1:0] cr_field;
        logic             load;
        logic             store;
        logic             upd;
        logic             byte_sz;
        logic             half_sz;
        logic             word_sz;
    } fcp_attr_t;

    localparam int ATTR_W = $bits(fcp_attr_t);

    typedef enum logic [3:0] {
        FCP_CO_IDLE   = 4'h1,
        FCP_CO_DECODE = 4'h2,
        FCP_CO_ACK    = 4'h4,
        FCP_CO_EXEC   = 4'h8
    } fcp_co_state_t;

    typedef enum logic [3:0] {
        FCP_CT_IDLE  = 4'h1,
        FCP_CT_ISSUE = 4'h2,
        FCP_CT_WACK  = 4'h4,
        FCP_CT_WDONE = 4'h8
    } fcp_ct_state_t;

endpackage

// >>> design/fcp_link_if.sv
/*
 * link between the auxiliary-unit controller and the fabric co-processor
 * assumes both ends are clocked by the same co-processor clock
 */
`timescale 1ns/1ps
interface fcp_link_if;
    logic        instruction_valid_strobe;
    logic [0:31] instruction_word;
    logic        ctrl_decoded_flag;
    logic        decode_acknowledge;
    logic        decode_busy_hold;
    logic        execution_complete;
    logic        sleep_inhibit;
    logic [0:31] coproc_result_bus;
    logic        writeback_flag;
    logic        operand_a_needed;
    logic        operand_b_needed;
    logic        privileged_only_flag;
    logic        force_word_align_flag;
    logic        overflow_return_flag;
    logic        carry_return_flag;
    logic        condition_update_flag;
    logic [0:2]  condition_field_select;
    logic        load_flag;
    logic        store_flag;
    logic        address_update_flag;
    logic        byte_size_flag;
    logic        halfword_size_flag;
    logic        word_size_flag;

    modport ctrl_mp (
        output instruction_valid_strobe, instruction_word, ctrl_decoded_flag,
        input  decode_acknowledge, decode_busy_hold, execution_complete, sleep_inhibit,
        input  coproc_result_bus, writeback_flag, operand_a_needed, operand_b_needed,
        input  privileged_only_flag, force_word_align_flag, overflow_return_flag,
        input  carry_return_flag, condition_update_flag, condition_field_select,
        input  load_flag, store_flag, address_update_flag, byte_size_flag,
        input  halfword_size_flag, word_size_flag
    );

    modport cop_mp (
        input  instruction_valid_strobe, instruction_word, ctrl_decoded_flag,
        output decode_acknowledge, decode_busy_hold, execution_complete, sleep_inhibit,
        output coproc_result_bus, writeback_flag, operand_a_needed, operand_b_needed,
        output privileged_only_flag, force_word_align_flag, overflow_return_flag,
        output carry_return_flag, condition_update_flag, condition_field_select,
        output load_flag, store_flag, address_update_flag, byte_size_flag,
        output halfword_size_flag, word_size_flag
    );
endinterface

// >>> design/fcp_ctrl_end.sv
/*
 * controller end of the co-processor link with an apb register slave
 * assumes the co-processor end shares core_clk_in, so link inputs need no synchroniser
 */
`timescale 1ns/1ps
module fcp_ctrl_end (
    input  wire logic                       core_clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       ce_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [fcp_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [fcp_pkg::WORD_W-1:0] pwdata_in,
    output logic      [fcp_pkg::WORD_W-1:0] prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    fcp_link_if.ctrl_mp                     link,
    output logic      [fcp_pkg::WORD_W-1:0] core_result_out,
    output logic                            core_result_valid_out,
    output logic                            core_sleep_block_out
);
    import fcp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fcp_ct_state_t      state_q;
    logic [1:0]         ctrl_q;
    logic [WORD_W-1:0]  word_q;
    logic [WORD_W-1:0]  result_q;
    logic [WORD_W-1:0]  prdata_q;
    fcp_attr_t          attr_q;
    logic               cdec_q;
    logic               hold_q;
    logic               res_valid_q;
    logic               ack_seen_q;
    logic               core_valid_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc     = psel_in & penable_in;
    wire hit     = paddr_in == REG_CTRL || paddr_in == REG_INSTR || paddr_in == REG_STATUS
                || paddr_in == REG_RESULT || paddr_in == REG_ATTR;
    wire wr      = acc & pwrite_in & hit;
    wire wr_ctrl = wr & (paddr_in == REG_CTRL);
    wire wr_ins  = wr & (paddr_in == REG_INSTR);
    wire wr_st   = wr & (paddr_in == REG_STATUS);
    wire idle    = state_q == FCP_CT_IDLE;
    wire issue   = wr_ins & idle & ctrl_q[CTRL_EN_BIT];
    wire done    = (state_q == FCP_CT_WDONE) & link.execution_complete;
    // an autonomous instruction completes without write-back, so no result is taken
    wire take    = done & (cdec_q | attr_q.writeback);
    wire res_clr = wr_st & pwdata_in[ST_RES_BIT];

    wire [WORD_W-1:0] status = {27'h0, hold_q, link.sleep_inhibit, ack_seen_q,
                                res_valid_q, ~idle};
    wire [WORD_W-1:0] rd_mux =
        (paddr_in == REG_CTRL)   ? {30'h0, ctrl_q} :
        (paddr_in == REG_INSTR)  ? word_q :
        (paddr_in == REG_STATUS) ? status :
        (paddr_in == REG_RESULT) ? result_q :
        (paddr_in == REG_ATTR)   ? {15'h0, attr_q} : 32'h0;

    wire fcp_attr_t link_attr = '{
        writeback: link.writeback_flag,        op_a:    link.operand_a_needed,
        op_b:      link.operand_b_needed,      priv:    link.privileged_only_flag,
        align:     link.force_word_align_flag, ovf:     link.overflow_return_flag,
        carry:     link.carry_return_flag,     cr_upd:  link.condition_update_flag,
        cr_field:  link.condition_field_select, load:   link.load_flag,
        store:     link.store_flag,            upd:     link.address_update_flag,
        byte_sz:   link.byte_size_flag,        half_sz: link.halfword_size_flag,
        word_sz:   link.word_size_flag};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= FCP_CT_IDLE;
            cdec_q  <= 1'b0;
            hold_q  <= 1'b0;
        end else if (ce_in) begin
            case (state_q)
                FCP_CT_IDLE: begin
                    if (issue) begin
                        cdec_q  <= ctrl_q[CTRL_CDEC_BIT];
                        state_q <= FCP_CT_ISSUE;
                    end
                end
                FCP_CT_ISSUE: begin
                    hold_q  <= link.decode_busy_hold;
                    state_q <= cdec_q ? FCP_CT_WDONE : FCP_CT_WACK;
                end
                FCP_CT_WACK: begin
                    if (!link.decode_busy_hold) begin
                        hold_q <= 1'b0;
                    end
                    if (link.decode_acknowledge) begin
                        state_q <= FCP_CT_WDONE;
                    end
                end
                FCP_CT_WDONE: begin
                    hold_q <= 1'b0;
                    if (link.execution_complete) begin
                        state_q <= FCP_CT_IDLE;
                    end
                end
                default: state_q <= FCP_CT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_q       <= CTRL_RST;
            word_q       <= '0;
            result_q     <= '0;
            attr_q       <= '0;
            prdata_q     <= '0;
            res_valid_q  <= 1'b0;
            ack_seen_q   <= 1'b0;
            core_valid_q <= 1'b0;
        end else if (ce_in) begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata_in[1:0];
            end
            if (issue) begin
                word_q <= pwdata_in;
            end
            if ((state_q == FCP_CT_WACK) & link.decode_acknowledge) begin
                attr_q <= link_attr;
            end
            if (take) begin
                result_q <= link.coproc_result_bus;
            end
            res_valid_q  <= take | (res_valid_q & ~res_clr);
            ack_seen_q   <= (state_q == FCP_CT_WACK & link.decode_acknowledge)
                          | (ack_seen_q & ~issue);
            core_valid_q <= take;
            if (psel_in & ~penable_in) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // word valid only when presented
    assign link.instruction_word = (state_q == FCP_CT_ISSUE | hold_q) ? word_q : 32'h0;
    assign link.instruction_valid_strobe = state_q == FCP_CT_ISSUE;
    assign link.ctrl_decoded_flag        = (state_q == FCP_CT_ISSUE) & cdec_q;

    assign prdata_out            = prdata_q;
    assign pready_out            = 1'b1;
    assign pslverr_out           = acc & ~hit;
    assign core_result_out       = result_q;
    assign core_result_valid_out = core_valid_q;
    assign core_sleep_block_out  = link.sleep_inhibit;
endmodule

// >>> design/fcp_coproc_end.sv
/*
 * fabric co-processor end of the link: captures instructions, runs the
 * decode and execute handshakes with user logic, returns flags and result
 * assumes the controller end shares core_clk_in and user logic is on it too
 */
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module fcp_coproc_end #(
    parameter bit HOLD_MODE = 1'b0
) (
    input  wire logic                       core_clk_in,
    input  wire logic                       reset_in,
    input  wire logic                       ce_in,
    fcp_link_if.cop_mp                      link,
    output logic                            dec_req_out,
    output logic      [fcp_pkg::WORD_W-1:0] dec_word_out,
    input  wire logic                       dec_done_in,
    input  wire fcp_pkg::fcp_dec_t          dec_info_in,
    output logic                            exec_start_out,
    input  wire logic                       exec_done_in,
    input  wire logic [fcp_pkg::WORD_W-1:0] exec_result_in,
    input  wire logic                       user_active_in
);
    import fcp_pkg::*;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (HOLD_MODE !== 1'b0 && HOLD_MODE !== 1'b1) begin : g_bad_mode
            $error("hold mode must be 0 or 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // attribute conversion
    // ------------------------------------------------------------
    function automatic fcp_attr_t to_attr(input fcp_dec_t d);
        fcp_attr_t a;
        logic      ls;
        ls = d.load | d.store;
        a  = '0;
        a.writeback = d.writeback;
        a.op_a      = d.op_a;
        a.op_b      = d.op_b;
        a.priv      = d.priv;
        a.align     = d.align & ls;
        a.ovf       = d.ovf;
        a.carry     = d.carry;
        a.cr_upd    = d.cr_upd;
        a.cr_field  = d.cr_field;
        a.load      = d.load;
        a.store     = d.store;
        a.upd       = d.upd & ls;
        a.byte_sz   = ls & (d.size == FCP_SZ_BYTE);
        a.half_sz   = ls & (d.size == FCP_SZ_HALF);
        a.word_sz   = ls & (d.size != FCP_SZ_BYTE) & (d.size != FCP_SZ_HALF);
        return a;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fcp_co_state_t     state_q;
    fcp_co_state_t     state_d;
    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] result_q;
    fcp_attr_t         attr_q;
    logic              auto_q;
    logic              done_q;

    wire strobe    = link.instruction_valid_strobe;
    wire st_idle   = state_q == FCP_CO_IDLE;
    wire st_decode = state_q == FCP_CO_DECODE;
    wire st_ack    = state_q == FCP_CO_ACK;
    wire st_exec   = state_q == FCP_CO_EXEC;
    wire own_start = st_idle & strobe & link.ctrl_decoded_flag;
    wire dec_take  = st_decode & dec_done_in;
    wire exec_end  = st_exec & exec_done_in;
    wire auto_end  = st_ack & auto_q;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            FCP_CO_IDLE: begin
                // own decodes go straight to execution
                if (strobe) begin
                    state_d = link.ctrl_decoded_flag ? FCP_CO_EXEC : FCP_CO_DECODE;
                end
            end
            FCP_CO_DECODE: begin
                // busy stays high until user decode ends
                if (dec_done_in) begin
                    state_d = FCP_CO_ACK;
                end
            end
            FCP_CO_ACK: begin
                // autonomous work leaves the link free
                state_d = auto_q ? FCP_CO_IDLE : FCP_CO_EXEC;
            end
            FCP_CO_EXEC: begin
                if (exec_done_in) begin
                    state_d = FCP_CO_IDLE;
                end
            end
            default: state_d = FCP_CO_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= FCP_CO_IDLE;
            word_q  <= '0;
            attr_q  <= '0;
            auto_q  <= 1'b0;
        end else if (ce_in) begin
            state_q <= state_d;
            // capture word on the strobe cycle
            if (st_idle & strobe) begin
                word_q <= link.instruction_word;
            end
            if (dec_take) begin
                attr_q <= to_attr(dec_info_in);
                auto_q <= dec_info_in.autonomous;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            result_q <= '0;
            done_q   <= 1'b0;
        end else if (ce_in) begin
            // result kept until the next one
            if (exec_end) begin
                result_q <= exec_result_in;
            end
            done_q <= exec_end | auto_end;
        end
    end

    // ------------------------------------------------------------
    // link outputs
    // ------------------------------------------------------------
    // every output but sleep_inhibit from state of this clock; sleep_inhibit also follows user_active_in directly
    assign link.decode_acknowledge = st_ack;
    // busy in idle asks the controller to hold
    assign link.decode_busy_hold   = st_idle ? HOLD_MODE : ~st_ack;
    assign link.execution_complete = done_q;
    assign link.sleep_inhibit      = ~st_idle | user_active_in;
    assign link.coproc_result_bus  = result_q;

    assign link.writeback_flag         = attr_q.writeback;
    assign link.operand_a_needed       = attr_q.op_a;
    assign link.operand_b_needed       = attr_q.op_b;
    assign link.privileged_only_flag   = attr_q.priv;
    assign link.force_word_align_flag  = attr_q.align;
    assign link.overflow_return_flag   = attr_q.ovf;
    assign link.carry_return_flag      = attr_q.carry;
    assign link.condition_update_flag  = attr_q.cr_upd;
    assign link.condition_field_select = attr_q.cr_field;
    assign link.load_flag              = attr_q.load;
    assign link.store_flag             = attr_q.store;
    assign link.address_update_flag    = attr_q.upd;
    assign link.byte_size_flag         = attr_q.byte_sz;
    assign link.halfword_size_flag     = attr_q.half_sz;
    assign link.word_size_flag         = attr_q.word_sz;

    // ------------------------------------------------------------
    // user outputs
    // ------------------------------------------------------------
    assign dec_req_out    = st_decode;
    assign dec_word_out   = word_q;
    assign exec_start_out = st_ack | own_start;
endmodule

// >>> tb/fcp_link_chk.sv
/* checks on the co-processor link signals
   assumes one clock and a synchronous high reset */
`timescale 1ns/1ps
module fcp_link_chk (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic instruction_valid_strobe,
    input wire logic ctrl_decoded_flag,
    input wire logic decode_acknowledge,
    input wire logic decode_busy_hold,
    input wire logic execution_complete,
    input wire logic load_flag,
    input wire logic store_flag,
    input wire logic byte_size_flag,
    input wire logic halfword_size_flag,
    input wire logic word_size_flag
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire       ls = load_flag | store_flag;
    wire [2:0] sz = {byte_size_flag, halfword_size_flag, word_size_flag};
    wire       sv = instruction_valid_strobe;
    wire       ak = decode_acknowledge;
    property p_ak_nb; ak |-> !decode_busy_hold; endproperty
    a_ak_nb: assert property (p_ak_nb) else $error("ack with busy high");
    property p_ak_ns; sv |-> !ak; endproperty
    a_ak_ns: assert property (p_ak_ns) else $error("ack with strobe");
    property p_ak_by; sv && !ctrl_decoded_flag |-> ##[2:60] ak; endproperty
    a_ak_by: assert property (p_ak_by) else $error("ack missing");
    property p_ak_pl; ak |=> !ak; endproperty
    a_ak_pl: assert property (p_ak_pl) else $error("ack too long");
    property p_sz1; ak && ls |-> $onehot(sz); endproperty
    a_sz1: assert property (p_sz1) else $error("size not one-hot");
    property p_sz0; ak && !ls |-> sz == 3'h0; endproperty
    a_sz0: assert property (p_sz0) else $error("size without load/store");
    property p_cd; sv && ctrl_decoded_flag |=> !ak [*4]; endproperty
    a_cd: assert property (p_cd) else $error("ack for own decode");
    property p_dn; execution_complete |=> !execution_complete; endproperty
    a_dn: assert property (p_dn) else $error("complete too long");
endmodule

// >>> tb/fcp_link_bench.sv
/* bench: apb master on the controller end, user logic stand-in on the co-processor end
   assumes both ends share one 50 MHz clock */
`timescale 1ns/1ps
module fcp_link_bench;
    import fcp_pkg::*;
    logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, dd = 0, xd = 0, pd = 0, act = 0, se, cd;
    logic [7:0] ad = 8'h00;
    logic [31:0] wd = 32'h0, xr = 32'h0, rd, lt = 32'h0, r;
    logic [15:0] lf = 16'h005f, rs = 16'h005f;
    fcp_dec_t inf = '0, nf;
    wire [31:0] prd, dw, cr;
    wire rdy, err, drq, xs, rv, sb;
    int errors = 0, total_checks = 0;
    int nres = 0, eres = 0;
    fcp_link_if lk ();
    fcp_ctrl_end fcp_ctrl_end_i (.core_clk_in(clk), .reset_in(rst), .ce_in(1'b1), .psel_in(sel),
        .penable_in(en), .pwrite_in(wr), .paddr_in(ad), .pwdata_in(wd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(err), .link(lk.ctrl_mp), .core_result_out(cr),
        .core_result_valid_out(rv), .core_sleep_block_out(sb));
    fcp_coproc_end fcp_coproc_end_i (.core_clk_in(clk), .reset_in(rst), .ce_in(1'b1),
        .link(lk.cop_mp), .dec_req_out(drq), .dec_word_out(dw), .dec_done_in(dd),
        .dec_info_in(inf), .exec_start_out(xs), .exec_done_in(xd), .exec_result_in(xr),
        .user_active_in(act));
    fcp_link_chk fcp_link_chk_i (.core_clk_in(clk), .reset_in(rst),
        .instruction_valid_strobe(lk.instruction_valid_strobe),
        .ctrl_decoded_flag(lk.ctrl_decoded_flag), .decode_acknowledge(lk.decode_acknowledge),
        .decode_busy_hold(lk.decode_busy_hold), .execution_complete(lk.execution_complete),
        .load_flag(lk.load_flag), .store_flag(lk.store_flag), .byte_size_flag(lk.byte_size_flag),
        .halfword_size_flag(lk.halfword_size_flag), .word_size_flag(lk.word_size_flag));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] ea(input fcp_dec_t d);
        logic l;
        l = d.load | d.store;
        return {15'h0, d.writeback, d.op_a, d.op_b, d.priv, d.align & l, d.ovf, d.carry,
            d.cr_upd, d.cr_field, d.load, d.store, d.upd & l, l && d.size == FCP_SZ_BYTE,
            l && d.size == FCP_SZ_HALF, l && d.size[1]};
    endfunction
    initial forever #10 clk = ~clk;
    // user logic: random decode and execute delays
    always @(posedge clk) begin
        lf <= nx(lf);
        dd <= drq & !dd & lf[0];
        xd <= pd & lf[1];
        pd <= xs | (pd & !lf[1]);
        // count result pulses toward the core
        if (rv === 1'b1) nres <= nres + 1;
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk) begin sel <= 1; wr <= w; ad <= a; wd <= d; end
        @(posedge clk) en <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
        rd = prd;
        se = err;
        sel <= 0;
        en <= 0;
        if (n >= 50) begin errors++; stop_test; end
    endtask
    task automatic idle;
        int n;
        n = 0;
        do begin apb(0, REG_STATUS, 0); n++; end while (rd[0] !== 1'b0 && n < 100);
        if (n >= 100) begin errors++; stop_test; end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        apb(1, REG_CTRL, 32'h1);
        apb(0, 8'h14, 0);
        chk({31'h0, se}, 32'h1);
        for (int i = 0; i < 24; i++) begin
            rs = nx(rs);
            r = {rs, nx(rs)};
            rs = nx(rs);
            nf = fcp_dec_t'(r[16:0]);
            // autonomous work returns no result, so never with write-back
            nf.autonomous = r[17] & !nf.writeback;
            nf.cr_field = i[2:0];
            nf.size = fcp_size_t'(i[4:3]);
            cd = (i % 11 == 0);
            if (cd || nf.writeback) begin
                lt = r;
                eres++;
            end
            if (cd) apb(1, REG_CTRL, 32'h3);
            @(posedge clk) begin inf <= nf; xr <= r; act <= r[20]; end
            apb(1, REG_INSTR, ~r);
            idle;
            chk({31'h0, rd[2]}, {31'h0, !cd});
            chk({31'h0, rd[3]}, {31'h0, act});
            if (cd) apb(1, REG_CTRL, 32'h1);
            chk(dw, ~r);
            apb(0, REG_RESULT, 0);
            chk(rd, lt);
            chk(cr, lt);
            apb(0, REG_ATTR, 0);
            if (!cd) chk(rd, ea(nf));
            chk({31'h0, sb}, {31'h0, act});
        end
        chk(nres, eres);
        stop_test;
    end
endmodule
